// *** rtl/pbg_cfg.svh ***
`ifndef PBG_CFG_SVH
`define PBG_CFG_SVH
// register word addresses (consecutive, one per register)
`define PBG_ADDR_DATA 4'h0
`define PBG_ADDR_DIR 4'h1
`define PBG_ADDR_PULL 4'h2
`define PBG_ADDR_SLEW 4'h3
`define PBG_ADDR_DRIVE 4'h4
`define PBG_ADDR_SC 4'h5
`define PBG_ADDR_SEL 4'h6
`define PBG_ADDR_POL 4'h7
`define PBG_ADDR_ISTAT 4'h8
`define PBG_ADDR_IMASK 4'h9
// status/control field positions
`define PBG_SC_FLAG 3
`define PBG_SC_ACK 2
`define PBG_SC_IE 1
`define PBG_SC_MOD 0
// number of interrupt-capable pins
`define PBG_IRQ_PINS 4
// reset values
`define PBG_RST_8 8'h00
`define PBG_RST_4 4'h0
`endif

// *** rtl/pbg_pkg.sv ***
package pbg_pkg;
   // one avalon request
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] addr;
      logic [31:0] wdata;
   } pbg_req_s;
   // bus answer states
   typedef enum logic [1:0] {
      PBG_IDLE = 2'b01,
      PBG_DONE = 2'b10
   } pbg_bus_e;
   typedef logic [7:0] pbg_byte_t;
endpackage : pbg_pkg

// *** rtl/pbg_port.sv ***
`timescale 1ns/100ps
`include "pbg_cfg.svh"
// Behaviour
// RL1 - input pins: pull bit switches pull device
// RL2 - output pins: pull forced off
// RL3 - pull-down only for rising-polarity irq pins
// RL4 - slew bits act only on outputs
// RL5 - drive bits act only on outputs
// RL6 - flag bit 3 shows event, writes ignored
// RL7 - write one to bit 2 clears flag
// RL8 - request only when flag and enable set
// RL9 - mode bit: edges only or edges and levels
// RL10 - select bit admits pin as irq source
// RL11 - polarity bit picks pull and sense
// RL12 - direction drives pin, data read muxed
// RL13 - reset clears latch, inputs, pulls off
// RL14 - selected pins ORed into one flag
// RL15 - level mode: ack cannot clear active level
module pbg_port
(
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   input wire logic CE_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [3:0] AVS_ADDRESS_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic [7:0] PIN_IN,
   output logic [7:0] PIN_OUT,
   output logic [7:0] PIN_OE_OUT,
   output logic [7:0] PULL_EN_OUT,
   output logic [7:0] PULL_DOWN_OUT,
   output logic [7:0] SLEW_EN_OUT,
   output logic [7:0] DRIVE_HIGH_OUT,
   output logic PORT_IRQ_OUT,
   output logic IRQ_OUT
);
   // ***********************************************
   // registers and synchronisers
   // ***********************************************
   pbg_pkg::pbg_byte_t latch_reg; // port output latch
   pbg_pkg::pbg_byte_t dir_reg; // port direction bits
   pbg_pkg::pbg_byte_t pull_reg; // pull enable bits
   pbg_pkg::pbg_byte_t slew_reg; // slew enable bits
   pbg_pkg::pbg_byte_t drive_reg; // drive select bits
   logic [3:0] sel_reg; // irq pin select bits
   logic [3:0] pol_reg; // irq polarity bits
   logic ie_reg; // irq enable
   logic mod_reg; // detect mode
   logic flag_reg; // irq flag
   logic [1:0] istat_reg; // sticky: 0 flag set, 1 ack done
   logic [1:0] imask_reg; // mask of istat
   pbg_pkg::pbg_byte_t meta_reg; // first sync stage, read only by sync_reg
   pbg_pkg::pbg_byte_t sync_reg; // second sync stage
   logic [3:0] act_prev_reg; // previous active-level view
   pbg_pkg::pbg_bus_e bus_reg; // bus answer state
   logic [31:0] rdata_reg; // read data
   pbg_pkg::pbg_req_s req; // bundled request
   logic [3:0] act_now; // pins at active level
   logic [3:0] edge_hit; // active-going edges
   logic event_hit; // qualifying event this cycle
   logic wr_go; // write accepted this cycle
   logic ack_go; // acknowledge written
   logic [31:0] rdata_next;

   // write helper: decode one address
   function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
      hit = (a == b);
   endfunction : hit

   assign req = '{read: AVS_READ_IN, write: AVS_WRITE_IN, addr: AVS_ADDRESS_IN, wdata: AVS_WRITEDATA_IN};

   // ***********************************************
   // avalon slave: one wait cycle, answer in DONE
   // ***********************************************
   // waitrequest low only in DONE so reads see registered data
   assign AVS_WAITREQUEST_OUT = !(bus_reg == pbg_pkg::PBG_DONE);
   assign wr_go = CE_IN && req.write && (bus_reg == pbg_pkg::PBG_DONE);
   assign ack_go = wr_go && hit(req.addr, `PBG_ADDR_SC) && req.wdata[`PBG_SC_ACK]; // RL7

   // bus state advance
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         bus_reg <= pbg_pkg::PBG_IDLE;
      else if (CE_IN)
      begin
         case (bus_reg)
            pbg_pkg::PBG_IDLE:
            begin
               if (req.read || req.write)
                  bus_reg <= pbg_pkg::PBG_DONE;
            end
            pbg_pkg::PBG_DONE: bus_reg <= pbg_pkg::PBG_IDLE;
            default: bus_reg <= pbg_pkg::PBG_IDLE;
         endcase
      end
   end

   // read mux; unmapped reads return zero
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      case (req.addr)
         `PBG_ADDR_DATA: rdata_next[7:0] = (dir_reg & latch_reg) | (~dir_reg & sync_reg); // RL12
         `PBG_ADDR_DIR: rdata_next[7:0] = dir_reg;
         `PBG_ADDR_PULL: rdata_next[7:0] = pull_reg;
         `PBG_ADDR_SLEW: rdata_next[7:0] = slew_reg;
         `PBG_ADDR_DRIVE: rdata_next[7:0] = drive_reg;
         // ack always reads zero
         `PBG_ADDR_SC: rdata_next[3:0] = {flag_reg, 1'b0, ie_reg, mod_reg}; // RL6 RL7
         `PBG_ADDR_SEL: rdata_next[3:0] = sel_reg;
         `PBG_ADDR_POL: rdata_next[3:0] = pol_reg;
         `PBG_ADDR_ISTAT: rdata_next[1:0] = istat_reg;
         `PBG_ADDR_IMASK: rdata_next[1:0] = imask_reg;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // capture read data while waiting
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         rdata_reg <= 32'h0000_0000;
      else if (CE_IN && bus_reg == pbg_pkg::PBG_IDLE && req.read)
         rdata_reg <= rdata_next;
   end
   assign AVS_READDATA_OUT = rdata_reg;

   // ***********************************************
   // control registers
   // ***********************************************
   // plain writes; reset leaves all pins as inputs
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         latch_reg <= `PBG_RST_8; // RL13
         dir_reg <= `PBG_RST_8; // RL13
         pull_reg <= `PBG_RST_8; // RL13
         slew_reg <= `PBG_RST_8;
         drive_reg <= `PBG_RST_8;
         sel_reg <= `PBG_RST_4;
         pol_reg <= `PBG_RST_4;
         ie_reg <= 1'b0;
         mod_reg <= 1'b0;
         imask_reg <= 2'b00;
      end
      else if (wr_go)
      begin
         if (hit(req.addr, `PBG_ADDR_DATA)) latch_reg <= req.wdata[7:0];
         if (hit(req.addr, `PBG_ADDR_DIR)) dir_reg <= req.wdata[7:0];
         if (hit(req.addr, `PBG_ADDR_PULL)) pull_reg <= req.wdata[7:0];
         if (hit(req.addr, `PBG_ADDR_SLEW)) slew_reg <= req.wdata[7:0];
         if (hit(req.addr, `PBG_ADDR_DRIVE)) drive_reg <= req.wdata[7:0];
         if (hit(req.addr, `PBG_ADDR_SEL)) sel_reg <= req.wdata[3:0];
         if (hit(req.addr, `PBG_ADDR_POL)) pol_reg <= req.wdata[3:0];
         if (hit(req.addr, `PBG_ADDR_IMASK)) imask_reg <= req.wdata[1:0];
         if (hit(req.addr, `PBG_ADDR_SC))
         begin
            ie_reg <= req.wdata[`PBG_SC_IE];
            mod_reg <= req.wdata[`PBG_SC_MOD];
         end
      end
   end

   // ***********************************************
   // pin side
   // ***********************************************
   // two-stage synchroniser on the pins
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         meta_reg <= `PBG_RST_8;
         sync_reg <= `PBG_RST_8;
      end
      else if (CE_IN)
      begin
         meta_reg <= PIN_IN;
         sync_reg <= meta_reg;
      end
   end

   assign PIN_OUT = latch_reg; // data is a flop
   assign PIN_OE_OUT = dir_reg; // RL12
   assign PULL_EN_OUT = pull_reg & ~dir_reg; // RL1 RL2
   // pull-down only on enabled, rising-sense irq pins
   assign PULL_DOWN_OUT = PULL_EN_OUT & {4'h0, sel_reg & pol_reg}; // RL3 RL11
   assign SLEW_EN_OUT = slew_reg & dir_reg; // RL4
   assign DRIVE_HIGH_OUT = drive_reg & dir_reg; // RL5

   // ***********************************************
   // interrupt detector
   // ***********************************************
   // xnor with polarity: 1 = at active level
   assign act_now = ~(sync_reg[3:0] ^ pol_reg) & sel_reg; // RL10 RL11
   assign edge_hit = act_now & ~act_prev_reg;
   // OR of selected pins; levels count only in mode 1
   assign event_hit = (|edge_hit) || (mod_reg && (|act_now)); // RL9 RL14

   // edge memory; reset value makes active pins look inactive
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         act_prev_reg <= `PBG_RST_4;
      else if (CE_IN)
         act_prev_reg <= act_now;
   end

   // flag: set wins over acknowledge, which keeps level mode set
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         flag_reg <= 1'b0;
      else if (CE_IN)
      begin
         if (event_hit)
            flag_reg <= 1'b1; // RL6 RL15
         else if (ack_go)
            flag_reg <= 1'b0; // RL7
      end
   end

   assign PORT_IRQ_OUT = flag_reg && ie_reg; // RL8

   // ***********************************************
   // sticky status with mask
   // ***********************************************
   // write one to clear; a new event wins over the clear
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         istat_reg <= 2'b00;
      else if (CE_IN)
      begin
         if (wr_go && hit(req.addr, `PBG_ADDR_ISTAT))
            istat_reg <= istat_reg & ~req.wdata[1:0] | {ack_go, event_hit && !flag_reg};
         else
            istat_reg <= istat_reg | {ack_go, event_hit && !flag_reg};
      end
   end
   assign IRQ_OUT = |(istat_reg & imask_reg);

   // ***********************************************
   // checks
   // ***********************************************
   sequence s_ack_write;
      wr_go && hit(req.addr, `PBG_ADDR_SC) && req.wdata[`PBG_SC_ACK] && !event_hit;
   endsequence
   sequence s_flag_low;
      !flag_reg;
   endsequence

   AST_ACK_CLEARS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) s_ack_write |=> s_flag_low) // RL7
      else $error("ack did not clear flag");
   // any qualifying event must show in the flag one edge later
   AST_EVENT_SETS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL6
      (CE_IN && event_hit) |=> flag_reg)
      else $error("event did not set flag");
   // request line is the flag gated by the enable, nothing else
   AST_IRQ_GATE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL8
      PORT_IRQ_OUT == (flag_reg && ie_reg))
      else $error("port irq wrong");
   // an output pin never carries a pull device
   AST_PULL_OUTPUT_OFF: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL2
      (PULL_EN_OUT & dir_reg) == 8'h00)
      else $error("pull active on output");
   // on inputs the pull follows its enable bit
   AST_PULL_FOLLOWS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL1
      (PULL_EN_OUT | dir_reg) == (pull_reg | dir_reg))
      else $error("pull not following bit");
   // pull-down only where a rising-sense irq pin is selected
   AST_PULLDOWN_ONLY_IRQ: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL3
      (PULL_DOWN_OUT[3:0] & ~(sel_reg & pol_reg)) == 4'h0 && PULL_DOWN_OUT[7:4] == 4'h0)
      else $error("pull-down misapplied");
   // slew and drive selections are dead on inputs
   AST_SLEW_DRIVE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL4 RL5
      ((SLEW_EN_OUT | DRIVE_HIGH_OUT) & ~dir_reg) == 8'h00)
      else $error("slew or drive on input");
   // a held active level keeps the flag up in level mode
   AST_LEVEL_HOLDS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL15
      (CE_IN && mod_reg && (|act_now)) |=> flag_reg)
      else $error("level mode lost flag");
   // with no pin selected the detector stays silent
   AST_UNSELECTED: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL10
      (sel_reg == 4'h0) |-> !event_hit)
      else $error("unselected pin raised event");
   // in edge mode a steady level is no event
   AST_EDGE_ONLY: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL9
      (CE_IN && !mod_reg && act_now == $past(act_now) && $past(CE_IN) && !$past(flag_reg) && !flag_reg
       && $stable(sel_reg) && $stable(pol_reg)) |-> !event_hit)
      else $error("steady level in edge mode");
   // a taken request is answered on the following edge
   AST_BUS_ANSWER: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL12
      (CE_IN && AVS_WAITREQUEST_OUT && (AVS_READ_IN || AVS_WRITE_IN)) |=> !AVS_WAITREQUEST_OUT || !CE_IN)
      else $error("bus did not answer");

   // ***********************************************
   // further checks: bus side effects and freezing
   // ***********************************************
   // a status/control read taken at an idle edge
   sequence s_sc_read;
      CE_IN && req.read && (bus_reg == pbg_pkg::PBG_IDLE) && hit(req.addr, `PBG_ADDR_SC);
   endsequence
   // a status/control write carrying no acknowledge
   sequence s_sc_plain_write;
      wr_go && hit(req.addr, `PBG_ADDR_SC) && !req.wdata[`PBG_SC_ACK] && !event_hit;
   endsequence
   // a direction write landing this cycle
   sequence s_dir_write;
      wr_go && hit(req.addr, `PBG_ADDR_DIR);
   endsequence

   // the acknowledge position must never read back as one
   AST_ACK_READS_ZERO: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL7
      s_sc_read |=> !AVS_READDATA_OUT[`PBG_SC_ACK])
      else $error("ack bit read as one");

   // software cannot write the flag directly
   AST_FLAG_WRITE_IGNORED: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL6
      s_sc_plain_write |=> (flag_reg == $past(flag_reg)))
      else $error("flag changed by plain write");

   // a direction write reaches the output enables at once
   AST_DIR_WRITE_LANDS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL12
      s_dir_write |=> (PIN_OE_OUT == $past(req.wdata[7:0])))
      else $error("direction write lost");

   // a fresh flag always leaves its mark in the sticky status
   AST_STICKY_SETS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN) // RL14
      (CE_IN && event_hit && !flag_reg) |=> istat_reg[0])
      else $error("sticky status missed event");

   // clock enable low freezes detector, bus and status alike
   AST_CE_FREEZE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      !CE_IN |=> $stable(flag_reg) && $stable(bus_reg) && $stable(istat_reg) && $stable(sync_reg))
      else $error("state moved while frozen");
endmodule : pbg_port

// *** bench/pbg_pins_model.sv ***
`timescale 1ns/100ps
// ****
// pads of port b as seen from the board
// ****
module pbg_pins_model
(
   input wire logic clk_in,
   input wire logic [7:0] oe_in,
   input wire logic [7:0] out_in,
   input wire logic [7:0] pull_en_in,
   input wire logic [7:0] pull_down_in,
   input wire logic [7:0] ext_en_in,
   input wire logic [7:0] ext_val_in,
   output logic [7:0] level_out
);
   // undriven pads wander every cycle, so a stale value never reads as a match
   logic [7:0] float_reg = 8'h5A;
   always @(posedge clk_in)
      float_reg <= ~float_reg;
   // our driver wins over the board; a real clash is not modelled
   always_comb
   begin
      for (int b = 0; b < 8; b++)
      begin
         if (oe_in[b])
            level_out[b] = out_in[b];
         else if (ext_en_in[b])
            level_out[b] = ext_val_in[b];
         else if (pull_en_in[b])
            level_out[b] = ~pull_down_in[b];
         else
            level_out[b] = float_reg[b];
      end
   end
endmodule : pbg_pins_model

// *** bench/tb_port_b_pin_control_and_irq.sv ***
`timescale 1ns/100ps
// ****
// self-checking bench for the port b block
// ****
module tb_port_b_pin_control_and_irq;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic ce_s = 1'b1; // clock enable, dropped once to prove the freeze
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata_o;
   logic wait_o, pirq_o, irq_o;
   logic [7:0] lvl, pin_o, oe_o, pull_o, pd_o, slew_o, drv_o;
   logic [7:0] ext_en = 8'h00; // board drives these pads
   logic [7:0] ext_val = 8'h00;
   logic [7:0] cfg [0:7]; // shadow of what was written, by address
   logic [3:0] pol;
   int i, j, k, m;
   int seed = 76;
   int n_errors = 0;
   int check_count = 0;
   always #2 clk_in = ~clk_in;
   pbg_port dut_u (.CLK_IN(clk_in), .RST_N_IN(rst_n_in), .CE_IN(ce_s), .AVS_READ_IN(rd_s), .AVS_WRITE_IN(wr_s),
      .AVS_ADDRESS_IN(addr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata_o), .AVS_WAITREQUEST_OUT(wait_o),
      .PIN_IN(lvl), .PIN_OUT(pin_o), .PIN_OE_OUT(oe_o), .PULL_EN_OUT(pull_o), .PULL_DOWN_OUT(pd_o),
      .SLEW_EN_OUT(slew_o), .DRIVE_HIGH_OUT(drv_o), .PORT_IRQ_OUT(pirq_o), .IRQ_OUT(irq_o));
   pbg_pins_model pins_u (.clk_in(clk_in), .oe_in(oe_o), .out_in(pin_o), .pull_en_in(pull_o),
      .pull_down_in(pd_o), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
   // verdict, reached from the main flow or a timed-out wait
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one avalon access: hold until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_in);
      rd_s <= ~w;
      wr_s <= w;
      addr <= a;
      wdata <= {24'h00_0000, d};
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (wait_o !== 1'b0 && n < 20);
      q = rdata_o;
      rd_s <= 1'b0;
      wr_s <= 1'b0;
      if (n >= 20)
      begin
         n_errors++;
         test_done();
      end
   endtask : bus
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h00_0000, e});
   endtask : rdc
   // pad change needs two sync edges and one detect edge
   task automatic pause();
      repeat (4) @(posedge clk_in);
   endtask : pause
   function automatic logic [7:0] exp_pd(input logic [7:0] pu, dr, se, po);
      return {4'h0, pu[3:0] & ~dr[3:0] & se[3:0] & po[3:0]};
   endfunction : exp_pd
   function automatic logic [7:0] exp_data(input logic [7:0] lat, dr, pad);
      return (lat & dr) | (pad & ~dr);
   endfunction : exp_data
   // ****
   // main sequence
   // ****
   initial
   begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk(32'({pin_o, oe_o, pull_o, pd_o}), 32'h0000_0000);
      chk(32'({slew_o, drv_o, 6'h00, pirq_o, irq_o}), 32'h0000_0000);
      wr(4'hA, 8'hFF);
      for (i = 1; i < 16; i++)
         rdc(i[3:0], 8'h00);
      $display("test reset and unmapped done");
      for (i = 0; i < 8; i++)
      begin
         for (j = 0; j < 8; j++)
            cfg[j] = (i < 2) ? {8{i[0]}} : 8'($random(seed));
         ext_en <= 8'hFF;
         ext_val <= cfg[5]; // address 5 is not a config byte, so its slot holds the pad value
         for (j = 0; j < 8; j++)
            if (j != 5) wr(j[3:0], cfg[j]);
         for (j = 1; j < 8; j++)
            if (j != 5) rdc(j[3:0], (j > 5) ? (cfg[j] & 8'h0F) : cfg[j]);
         rdc(4'h0, exp_data(cfg[0], cfg[1], cfg[5]));
         chk(32'(pull_o), 32'(cfg[2] & ~cfg[1]));
         chk(32'(pd_o), 32'(exp_pd(cfg[2], cfg[1], cfg[6], cfg[7])));
         chk(32'(slew_o), 32'(cfg[3] & cfg[1]));
         chk(32'(drv_o), 32'(cfg[4] & cfg[1]));
         chk(32'({pin_o, oe_o}), 32'({cfg[0], cfg[1]}));
      end
      $display("test pin configuration done");
      for (m = 0; m < 2; m++)
         for (k = 0; k < 4; k++)
         begin
            pol = 4'($random(seed));
            ext_val <= {4'h0, ~pol};
            wr(4'h1, 8'h00);
            wr(4'h7, {4'h0, pol});
            wr(4'h6, 8'h00);
            wr(4'h5, 8'h06 | 8'(m));
            rdc(4'h5, 8'h02 | 8'(m));
            ext_val[k] <= pol[k];
            pause();
            rdc(4'h5, 8'h02 | 8'(m));
            ext_val[k] <= ~pol[k];
            pause();
            wr(4'h6, 8'h01 << k);
            ext_val[k] <= pol[k];
            pause();
            rdc(4'h5, 8'h0A | 8'(m));
            @(negedge clk_in);
            chk(32'(pirq_o), 32'h0000_0001);
            wr(4'h5, 8'h08 | 8'(m));
            @(negedge clk_in);
            chk(32'(pirq_o), 32'h0000_0000);
            rdc(4'h5, 8'h08 | 8'(m));
            wr(4'h5, 8'h06 | 8'(m));
            pause();
            rdc(4'h5, 8'h02 | 8'(m) | ((m == 1) ? 8'h08 : 8'h00));
         end
      $display("test pin interrupt done");
      ce_s <= 1'b0; // freeze with the level still active
      repeat (3) @(posedge clk_in);
      chk(32'(pirq_o), 32'h0000_0001);
      ce_s <= 1'b1;
      rdc(4'h5, 8'h0B);
      wr(4'h9, 8'h00);
      rdc(4'h8, 8'h03);
      @(negedge clk_in);
      chk(32'(irq_o), 32'h0000_0000);
      wr(4'h9, 8'h01);
      rdc(4'h9, 8'h01);
      @(negedge clk_in);
      chk(32'(irq_o), 32'h0000_0001);
      wr(4'h8, 8'h01);
      rdc(4'h8, 8'h02);
      @(negedge clk_in);
      chk(32'(irq_o), 32'h0000_0000);
      $display("test status and mask done");
      test_done();
   end
endmodule : tb_port_b_pin_control_and_irq
